// *** include/ptwcp_defs.svh ***
// constants of the three-wire panel configuration port
`ifndef PTWCP_DEFS_SVH
`define PTWCP_DEFS_SVH
`define PTWCP_FRAME_BITS     16
`define PTWCP_ADDR_MSB       15
`define PTWCP_ADDR_LSB       10
`define PTWCP_DIR_BIT        9
`define PTWCP_TURN_BIT       8
`define PTWCP_DATA_MSB       7
`define PTWCP_ADDR_CTRL_A    6'h00
`define PTWCP_ADDR_CTRL_B    6'h01
`define PTWCP_ADDR_CTRL_C    6'h02
`define PTWCP_RST_CTRL_A     8'hAD
`define PTWCP_RST_CTRL_B     8'h00
`define PTWCP_RST_CTRL_C     8'h00
`define PTWCP_MASK_CTRL_A    8'hBF
`define PTWCP_MASK_CTRL_B    8'hFE
`define PTWCP_MASK_CTRL_C    8'h40
`define PTWCP_WB_CMD         4'h0
`define PTWCP_WB_STAT        4'h4
`define PTWCP_CMD_GO_BIT     31
`define PTWCP_CMD_RD_BIT     30
`define PTWCP_STAT_BUSY_BIT  31
`define PTWCP_STAT_DONE_BIT  30
`define PTWCP_SCK_HALF       8'h03
`endif

// *** include/ptwcp_pkg.sv ***
// types shared by the configuration port ends
package ptwcp_pkg;
    typedef enum logic [3:0] {
        PTWCP_IDLE  = 4'h1,
        PTWCP_LOW   = 4'h2,
        PTWCP_HIGH  = 4'h4,
        PTWCP_END   = 4'h8
    } ptwcp_host_st_t;
    typedef enum logic [1:0] {
        PTWCP_RES_1024X600 = 2'h0,
        PTWCP_RES_1024X768 = 2'h1,
        PTWCP_RES_800X600  = 2'h2,
        PTWCP_RES_800X480  = 2'h3
    } ptwcp_res_t;
endpackage

// *** include/ptwcp_if.sv ***
// three-wire link between host and panel port
`timescale 1ns/10ps
interface ptwcp_if;
    logic serial_clock;
    logic serial_select_n;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    wire  sda;
    assign sda = sda_host_oe ? sda_host_o : (sda_dev_oe ? sda_dev_o : 1'b1);
    modport host (output serial_clock, output serial_select_n, output sda_host_o,
                  output sda_host_oe, input sda);
    modport device (input serial_clock, input serial_select_n, output sda_dev_o,
                    output sda_dev_oe, input sda);
endinterface

// *** logic/ptwcp_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/10ps
module ptwcp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // level in and out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    // first stage read only by second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '0;
            q_o     <= '0;
        end
        else
        begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule // ptwcp_sync

// *** logic/ptwcp_device.sv ***
// panel end: serial engine and system control registers
//
// Summary of operation
// - frame: six address bits, eight data bits
// - direction bit: zero writes, one reads
// - turnaround slot released on read, ignored on write
// - write data from host, read data from device
// - register 0 bit 0: sync mode, default 1
// - register 0 bit 1: pixel clock sampling edge
// - register 0 bit 2: soft reset, low holds
// - register 0 bit 3: standby, low powers down
// - register 0 bit 4: gate scan direction
// - register 0 bit 5: source shift direction
// - register 0 bit 7: power circuits enable
// - register 1 bits 2:1: resolution select
// - register 1 bit 3: built-in test pattern
// - register 1 bit 4: dithering enable
// - register 1 bit 5: frame-rate control, needs dither
// - register 1 bits 7:6: adaptive backlight mode
// - register 2 bit 6: panel polarity select
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`include "ptwcp_defs.svh"
module ptwcp_device (
    // link clock, system reset
    input  wire logic rst_i,
    ptwcp_if.device   link,
    // decoded controls
    output logic      sync_mode_strobe_o,
    output logic      pixel_clock_edge_select_o,
    output logic      global_soft_reset_n_o,
    output logic      standby_n_o,
    output logic      gate_scan_direction_o,
    output logic      scan_direction_out_o,
    output logic      vertical_start_sel_one_o,
    output logic      source_shift_direction_o,
    output logic      power_circuits_enable_o,
    output logic [1:0] resolution_select_o,
    output logic      channels_601_936_off_o,
    output logic      builtin_pattern_select_o,
    output logic      dither_enable_o,
    output logic      horizontal_frame_rate_ctrl_o,
    output logic      plain_frame_rate_ctrl_o,
    output logic [1:0] adaptive_backlight_select_o,
    output logic      panel_polarity_select_o,
    output logic      outputs_hiz_o
);
    logic        clk;
    logic [4:0]  cnt_ff;
    logic [14:0] shift_ff;
    logic        rd_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  rd_sel;
    logic [7:0]  reg_a_ff;
    logic [7:0]  reg_b_ff;
    logic [7:0]  reg_c_ff;
    logic [15:0] frame;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        in_frame;
    logic        dir_slot;
    logic        wr_commit;
    logic        rd_shift;
    logic        rd_drive;
    logic        rst_l_ff;
    logic        rst_l_meta_ff;

    ////////////////////////////////////////////////////////////////////////
    // link clock and the frame as seen at the current rising edge
    assign clk     = link.serial_clock;
    assign frame   = {shift_ff, link.sda};
    assign wr_addr = frame[`PTWCP_ADDR_MSB:`PTWCP_ADDR_LSB];
    assign wr_data = frame[`PTWCP_DATA_MSB:0];

    // strobes along the frame, counted in rising link edges
    assign in_frame  = !link.serial_select_n;
    assign dir_slot  = in_frame && cnt_ff == 5'h06;
    assign wr_commit = in_frame && cnt_ff == 5'h0F && !frame[`PTWCP_DIR_BIT];
    assign rd_shift  = in_frame && cnt_ff > 5'h07 && cnt_ff < 5'h10;
    // device owns the line from the first data bit to the end of the frame
    assign rd_drive  = rd_ff && cnt_ff >= 5'h08 && cnt_ff < 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // reset carried into the link domain; it needs link edges to act
    always_ff @(posedge clk)
    begin
        rst_l_meta_ff <= rst_i;
        rst_l_ff      <= rst_l_meta_ff;
    end

    // bit counter, cleared whenever select is high between frames
    always_ff @(posedge clk or posedge link.serial_select_n)
    begin
        if (link.serial_select_n)
            cnt_ff <= 5'h00;
        else if (cnt_ff != 5'h10)
            cnt_ff <= cnt_ff + 5'h01;
    end

    // msb-first shifting on rising edge
    always_ff @(posedge clk)
    begin
        shift_ff <= {shift_ff[13:0], link.sda};
    end

    // direction taken from the bit below the address
    always_ff @(posedge clk)
    begin
        if (dir_slot)
            rd_ff <= link.sda;
    end

    // register picked by the six address bits already shifted in
    always_comb
    begin
        unique case (shift_ff[5:0])
            `PTWCP_ADDR_CTRL_A: rd_sel = reg_a_ff;
            `PTWCP_ADDR_CTRL_B: rd_sel = reg_b_ff;
            `PTWCP_ADDR_CTRL_C: rd_sel = reg_c_ff;
            default:            rd_sel = 8'h00;
        endcase
    end

    // read data loaded at the direction bit, then shifted out msb first
    always_ff @(posedge clk)
    begin
        if (dir_slot)
            rdata_ff <= rd_sel;
        else if (rd_shift)
            rdata_ff <= {rdata_ff[6:0], 1'b0};
    end

    // line driven from falling edges so the host samples a settled bit
    always_ff @(negedge clk or posedge link.serial_select_n)
    begin
        if (link.serial_select_n)
            link.sda_dev_oe <= 1'b0;
        else
            link.sda_dev_oe <= rd_drive;
    end
    always_ff @(negedge clk)
    begin
        link.sda_dev_o <= rdata_ff[7];
    end

    ////////////////////////////////////////////////////////////////////////
    // register 0: sync, edge, resets, scan, power; bit 6 reserved
    always_ff @(posedge clk)
    begin
        if (rst_l_ff)
            reg_a_ff <= `PTWCP_RST_CTRL_A;
        else if (wr_commit && wr_addr == `PTWCP_ADDR_CTRL_A)
            reg_a_ff <= wr_data & `PTWCP_MASK_CTRL_A;
    end

    // register 1: resolution, pattern, dither, backlight; bit 0 reserved
    always_ff @(posedge clk)
    begin
        if (rst_l_ff)
            reg_b_ff <= `PTWCP_RST_CTRL_B;
        else if (wr_commit && wr_addr == `PTWCP_ADDR_CTRL_B)
            reg_b_ff <= wr_data & `PTWCP_MASK_CTRL_B;
    end

    // register 2: only polarity kept; the turnaround bit is never stored
    always_ff @(posedge clk)
    begin
        if (rst_l_ff)
            reg_c_ff <= `PTWCP_RST_CTRL_C;
        else if (wr_commit && wr_addr == `PTWCP_ADDR_CTRL_C)
            reg_c_ff <= wr_data & `PTWCP_MASK_CTRL_C;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs follow the registers one link edge later
    // register 0 decoded into control levels
    always_ff @(posedge clk)
    begin
        sync_mode_strobe_o           <= reg_a_ff[0];
        pixel_clock_edge_select_o    <= reg_a_ff[1];
        global_soft_reset_n_o        <= reg_a_ff[2];
        // standby low also cuts power and floats the panel outputs
        standby_n_o                  <= reg_a_ff[3];
        outputs_hiz_o                <= ~reg_a_ff[3];
        gate_scan_direction_o        <= reg_a_ff[4];
        scan_direction_out_o         <= reg_a_ff[4];
        vertical_start_sel_one_o     <= reg_a_ff[4];
        source_shift_direction_o     <= reg_a_ff[5];
        power_circuits_enable_o      <= reg_a_ff[7] & reg_a_ff[3];
    end

    // register 1 decoded; frame-rate controls only run with dithering
    always_ff @(posedge clk)
    begin
        resolution_select_o          <= reg_b_ff[2:1];
        channels_601_936_off_o       <= reg_b_ff[2:1] == ptwcp_pkg::PTWCP_RES_800X480;
        builtin_pattern_select_o     <= reg_b_ff[3];
        dither_enable_o              <= reg_b_ff[4];
        horizontal_frame_rate_ctrl_o <= reg_b_ff[4] & reg_b_ff[5];
        plain_frame_rate_ctrl_o      <= reg_b_ff[4];
        adaptive_backlight_select_o  <= reg_b_ff[7:6];
    end

    // register 2 decoded
    always_ff @(posedge clk)
    begin
        panel_polarity_select_o      <= reg_c_ff[6];
    end
endmodule // ptwcp_device

// *** logic/ptwcp_host.sv ***
// host end: wishbone slave that runs one three-wire frame per command
`timescale 1ns/10ps
`include "ptwcp_defs.svh"
module ptwcp_host (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // link
    ptwcp_if.host            link
);
    ptwcp_pkg::ptwcp_host_st_t st_ff;
    logic [7:0]  div_ff;
    logic [4:0]  bit_ff;
    logic [15:0] tx_ff;
    logic [7:0]  rx_ff;
    logic        busy_ff;
    logic        done_ff;
    logic        rd_cmd_ff;
    logic        sda_s;
    logic        req;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    ptwcp_sync #(.WIDTH(1)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (link.sda),
        .q_o   (sda_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus answer one cycle after request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0;
            if (req && !wb_we_i && wb_adr_i == `PTWCP_WB_STAT)
                wb_dat_o <= {busy_ff, done_ff, 22'h0, rx_ff};
        end
    end

    // frame engine, serial clock derived by divider, msb first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff                <= ptwcp_pkg::PTWCP_IDLE;
            div_ff               <= 8'h00;
            bit_ff               <= 5'h00;
            tx_ff                <= 16'h0;
            rx_ff                <= 8'h00;
            busy_ff              <= 1'b0;
            done_ff              <= 1'b0;
            rd_cmd_ff            <= 1'b0;
            link.serial_clock    <= 1'b0;
            link.serial_select_n <= 1'b1;
            link.sda_host_o      <= 1'b0;
            link.sda_host_oe     <= 1'b0;
        end
        else
        begin
            unique case (st_ff)
                ptwcp_pkg::PTWCP_IDLE:
                begin
                    if (req && wb_we_i && wb_adr_i == `PTWCP_WB_CMD && wb_sel_i[3]
                        && wb_dat_i[`PTWCP_CMD_GO_BIT])
                    begin
                        // address, direction, turnaround, data
                        tx_ff <= {wb_dat_i[13:8], wb_dat_i[`PTWCP_CMD_RD_BIT], 1'b0,
                                  wb_dat_i[7:0]};
                        rd_cmd_ff            <= wb_dat_i[`PTWCP_CMD_RD_BIT];
                        busy_ff              <= 1'b1;
                        done_ff              <= 1'b0;
                        bit_ff               <= 5'h00;
                        div_ff               <= 8'h00;
                        link.serial_select_n <= 1'b0;
                        st_ff                <= ptwcp_pkg::PTWCP_LOW;
                    end
                end
                ptwcp_pkg::PTWCP_LOW:
                begin
                    link.sda_host_o  <= tx_ff[15];
                    // release line from the turnaround slot to the end of a read
                    link.sda_host_oe <= !(rd_cmd_ff && bit_ff >= 5'h07);
                    div_ff <= div_ff + 8'h01;
                    if (div_ff == `PTWCP_SCK_HALF)
                    begin
                        div_ff            <= 8'h00;
                        link.serial_clock <= 1'b1;
                        st_ff             <= ptwcp_pkg::PTWCP_HIGH;
                    end
                end
                ptwcp_pkg::PTWCP_HIGH:
                begin
                    div_ff <= div_ff + 8'h01;
                    if (div_ff == `PTWCP_SCK_HALF)
                    begin
                        div_ff            <= 8'h00;
                        link.serial_clock <= 1'b0;
                        tx_ff             <= {tx_ff[14:0], 1'b0};
                        if (bit_ff > 5'h07)
                            rx_ff <= {rx_ff[6:0], sda_s};
                        bit_ff <= bit_ff + 5'h01;
                        st_ff  <= (bit_ff == 5'h0F) ? ptwcp_pkg::PTWCP_END
                                                    : ptwcp_pkg::PTWCP_LOW;
                    end
                end
                ptwcp_pkg::PTWCP_END:
                begin
                    link.serial_select_n <= 1'b1;
                    link.sda_host_oe     <= 1'b0;
                    busy_ff              <= 1'b0;
                    done_ff              <= 1'b1;
                    st_ff                <= ptwcp_pkg::PTWCP_IDLE;
                end
            endcase
        end
    end
endmodule // ptwcp_host

// *** verif/ptwcp_sva.sv ***
// checker of the three-wire link frames
`timescale 1ns/10ps
module ptwcp_chk (
    // host clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link signals
    input wire logic serial_clock,
    input wire logic serial_select_n,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
logic       sck_q_ff;
logic [4:0] cnt_ff;
logic       rd_ff;
logic       rise;
////////////////////////////////////////////////////////////////////////////////
// link clock rise inside a frame, seen in the host domain
assign rise = serial_clock && !sck_q_ff && !serial_select_n;
always_ff @(posedge clk_i)
begin
    sck_q_ff <= serial_clock;
end
// rising edges of the frame, cleared while select is high
always_ff @(posedge clk_i)
begin
    if (rst_i || serial_select_n)
    begin
        cnt_ff <= 5'h00;
    end
    else if (rise)
    begin
        cnt_ff <= cnt_ff + 5'h01;
    end
end
// direction bit caught at the seventh rising edge
always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        rd_ff <= 1'b0;
    end
    else if (rise && cnt_ff == 5'h06)
    begin
        rd_ff <= sda;
    end
end
////////////////////////////////////////////////////////////////////////////////
a_sclk_idle_low: assert property (serial_select_n && $past(serial_select_n) &&
    $past(serial_select_n, 2) |-> !serial_clock) else $error("clock moves outside a frame");
a_sclk_high_time: assert property ($rose(serial_clock) |->
    serial_clock[*4] ##1 !serial_clock) else $error("clock high phase wrong");
a_sclk_low_time: assert property ($fell(serial_clock) && !serial_select_n |->
    !serial_clock[*4]) else $error("clock low phase wrong");
a_frame_sixteen: assert property ($rose(serial_select_n) |-> cnt_ff == 5'h10)
    else $error("frame not sixteen bits");
a_one_driver: assert property (!(sda_host_oe && sda_dev_oe))
    else $error("both ends drive data");
a_host_head: assert property (rise && cnt_ff < 5'h07 |-> sda_host_oe)
    else $error("host not driving address or direction");
a_read_turn: assert property (rise && cnt_ff == 5'h07 && rd_ff |->
    !sda_host_oe && !sda_dev_oe) else $error("turnaround slot driven");
a_read_data: assert property (rise && cnt_ff >= 5'h08 && rd_ff |->
    sda_dev_oe && !sda_host_oe) else $error("read data not from device");
a_write_data: assert property (rise && cnt_ff >= 5'h07 && !rd_ff |->
    sda_host_oe && !sda_dev_oe) else $error("write data not from host");
c_read_frame: cover property ($rose(serial_select_n) && rd_ff);
c_write_frame: cover property ($rose(serial_select_n) && !rd_ff);
c_last_read_bit: cover property (rise && cnt_ff == 5'h0F && rd_ff);
endmodule // ptwcp_chk

// *** verif/ptwcp_test.sv ***
// testbench joining host and panel ends over the link
`timescale 1ns/10ps
`define CHK(n, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("FAIL %s exp %h got %h", n, e, g); \
        end \
    end
module ptwcp_test;
logic        clk_i = 1'b0;
logic        rst_i = 1'b1;
logic        dev_rst = 1'b1;
logic        cyc = 1'b0;
logic        stb = 1'b0;
logic        we = 1'b0;
logic [3:0]  adr = 4'h0;
logic [3:0]  sel = 4'h0;
logic [31:0] wdat = 32'h00000000;
logic [31:0] rdat;
logic        ack;
logic [9:0]  r0_out;
logic [8:0]  r1_out;
logic        pol;
logic [31:0] q;
int          n_mismatch = 0;
int          compares = 0;
int          cycles = 0;
ptwcp_if lnk ();
////////////////////////////////////////////////////////////////////////////////
// both ends and the link checker
ptwcp_host ptwcp_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(lnk));
ptwcp_device ptwcp_device_i (.rst_i(dev_rst), .link(lnk),
    .sync_mode_strobe_o(r0_out[0]), .pixel_clock_edge_select_o(r0_out[1]),
    .global_soft_reset_n_o(r0_out[2]), .outputs_hiz_o(r0_out[3]), .standby_n_o(r0_out[4]),
    .vertical_start_sel_one_o(r0_out[5]), .scan_direction_out_o(r0_out[6]),
    .gate_scan_direction_o(r0_out[7]), .source_shift_direction_o(r0_out[8]),
    .power_circuits_enable_o(r0_out[9]), .resolution_select_o(r1_out[1:0]),
    .channels_601_936_off_o(r1_out[2]), .builtin_pattern_select_o(r1_out[3]),
    .dither_enable_o(r1_out[4]), .plain_frame_rate_ctrl_o(r1_out[5]),
    .horizontal_frame_rate_ctrl_o(r1_out[6]), .adaptive_backlight_select_o(r1_out[8:7]),
    .panel_polarity_select_o(pol));
ptwcp_chk ptwcp_chk_i (.clk_i(clk_i), .rst_i(rst_i), .serial_clock(lnk.serial_clock),
    .serial_select_n(lnk.serial_select_n), .sda_host_o(lnk.sda_host_o),
    .sda_host_oe(lnk.sda_host_oe), .sda_dev_o(lnk.sda_dev_o),
    .sda_dev_oe(lnk.sda_dev_oe), .sda(lnk.sda));
////////////////////////////////////////////////////////////////////////////////
// clock and hang limit
always #50 clk_i = ~clk_i;
always @(posedge clk_i)
begin
    cycles++;
    if (cycles == 20000)
    begin
        n_mismatch++;
        summarize();
    end
end
// one classic wishbone cycle, waits for ack
task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                  output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
    begin
        @(posedge clk_i);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
endtask
// start a frame without waiting
task automatic cmd(input logic rd, input logic [5:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, 4'h0, {1'b1, rd, 16'h0000, a, d}, r);
endtask
// one frame, status polled until done
task automatic frame(input logic rd, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    logic [31:0] s;
    cmd(rd, a, d);
    wb(1'b0, 4'h4, 32'h00000000, s);
    while (s[31] !== 1'b0 || s[30] !== 1'b1)
    begin
        wb(1'b0, 4'h4, 32'h00000000, s);
    end
    r = s[7:0];
endtask
// register read back over the link
task automatic chk_reg(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    frame(1'b1, a, 8'h00, r);
    `CHK("reg", e, r)
endtask
// decoded controls of control registers 0 and 1
task automatic chk_r0(input logic [7:0] v);
    `CHK("ctrl_a", {v[7] & v[3], v[5], v[4], v[4], v[4], v[3], ~v[3], v[2:0]}, r0_out)
endtask
task automatic chk_r1(input logic [7:0] v);
    `CHK("ctrl_b", {v[7:6], v[5] & v[4], v[4], v[4], v[3], v[2] & v[1], v[2:1]}, r1_out)
endtask
// closing report
task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
// main sequence
initial
begin
    logic [7:0] r;
    logic [7:0] v;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    frame(1'b0, 6'h02, 8'h40, r);
    dev_rst <= 1'b0;
    frame(1'b1, 6'h00, 8'h00, r);
    chk_reg(6'h00, 8'hAD);
    chk_r0(8'hAD);
    chk_reg(6'h01, 8'h00);
    chk_reg(6'h02, 8'h00);
    `CHK("polarity", 1'b0, pol)
    frame(1'b0, 6'h00, 8'hFF, r);
    chk_reg(6'h00, 8'hBF);
    chk_r0(8'hBF);
    frame(1'b0, 6'h00, 8'hA5, r);
    chk_reg(6'h00, 8'hA5);
    chk_r0(8'hA5);
    for (int i = 0; i < 4; i++)
    begin
        v = {2'(i), i[0], i[1], i[0], 2'(i), 1'b1};
        frame(1'b0, 6'h01, v, r);
        chk_reg(6'h01, v & 8'hFE);
        chk_r1(v & 8'hFE);
    end
    cmd(1'b0, 6'h02, 8'hFF);
    cmd(1'b0, 6'h02, 8'h00);
    frame(1'b1, 6'h02, 8'h00, r);
    chk_reg(6'h02, 8'h40);
    `CHK("polarity", 1'b1, pol)
    frame(1'b0, 6'h05, 8'h5A, r);
    chk_reg(6'h05, 8'h00);
    wb(1'b0, 4'h8, 32'h00000000, q);
    `CHK("wb_unmapped", 32'h00000000, q)
    // device reset in mid-run: a write during it is lost, defaults return
    dev_rst <= 1'b1;
    frame(1'b0, 6'h00, 8'h00, r);
    dev_rst <= 1'b0;
    chk_reg(6'h00, 8'hAD);
    chk_r0(8'hAD);
    summarize();
end
endmodule // ptwcp_test
